// >>> lpm_pkg.sv
// Package for the low-power mode controller: modes, vector indices, timing.
// Assumes a single 20 MHz CPU clock domain.
package lpm_pkg;

    // Power modes
    typedef enum logic [2:0] {
        LPM_RUN     = 3'b000,
        LPM_WAIT    = 3'b001,
        LPM_AHALT   = 3'b010,
        LPM_HALT    = 3'b011,
        LPM_WAKEUP  = 3'b100,
        LPM_SERVICE = 3'b101
    } lpm_mode_type;

    // Wake-up delay in CPU cycles
    localparam int unsigned LPM_WAKE_DELAY_CYCLES = 4096;
    localparam int unsigned LPM_DELAY_WIDTH       = 13;

    // Clock rate
    localparam int unsigned LPM_CLK_PERIOD_NS = 50;

    // Interrupt sources
    localparam int unsigned LPM_NUM_IRQ = 14;
    localparam int unsigned LPM_IRQ_IDX = 4;
    localparam logic [3:0]  LPM_IRQ_TIMEBASE = 4'h1;

    // Vector addresses
    localparam logic [15:0] LPM_RESET_VECTOR = 16'hFFFE;
    localparam logic [15:0] LPM_VECTOR_TOP   = 16'hFFFC;

    // Reset values
    localparam logic        LPM_IMASK_RESET = 1'b1;

endpackage : lpm_pkg

// >>> lpm_wake_timer.sv
// Wake-up delay counter: counts a fixed number of CPU cycles after start.
// Assumes start is a one-cycle pulse from the mode controller.
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_timer #(
    parameter int unsigned DELAY = lpm_pkg::LPM_WAKE_DELAY_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    import lpm_pkg::*;

    logic [LPM_DELAY_WIDTH-1:0] count;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= LPM_DELAY_WIDTH'(DELAY - 1);
                busy  <= 1'b1;
            end else if (busy) begin
                if (count == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end
endmodule // lpm_wake_timer
`default_nettype wire

// >>> lpm_irq_select.sv
// Wake qualifier and priority encoder over the pending interrupt lines.
// Assumes line 0 has the highest priority among maskable sources.
`timescale 1ns/1ps
`default_nettype none
module lpm_irq_select #(
    parameter int unsigned NUM_IRQ = lpm_pkg::LPM_NUM_IRQ
) (
    // Pending and capability
    input  wire logic [NUM_IRQ-1:0] irq_pending,
    input  wire logic [NUM_IRQ-1:0] irq_halt_wake,
    input  wire logic               in_halt,
    // Results
    output logic                    wake,
    output logic [3:0]              irq_index
);
    import lpm_pkg::*;

    logic [NUM_IRQ-1:0] qualified;

    // Plain Halt excludes the time-base/clock-security line
    always_comb begin
        qualified = irq_pending;
        if (in_halt) begin
            qualified = irq_pending & irq_halt_wake;
        end
    end

    assign wake = |qualified;

    always_comb begin
        irq_index = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (qualified[i]) begin
                irq_index = 4'(i);
            end
        end
    end
endmodule // lpm_irq_select
`default_nettype wire

// >>> lpm_controller.sv
// Low-power mode controller: Wait, Active Halt and Halt entry/exit.
// Assumes CPU issues one-cycle instruction strobes; sources hold pending levels.
`timescale 1ns/1ps
`default_nettype none
module lpm_controller #(
    parameter int unsigned WAKE_DELAY = lpm_pkg::LPM_WAKE_DELAY_CYCLES,
    parameter int unsigned NUM_IRQ    = lpm_pkg::LPM_NUM_IRQ
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // CPU instruction strobes
    input  wire logic               wait_for_event_instruction,
    input  wire logic               halt_instruction,
    input  wire logic               irq_return,
    // Configuration
    input  wire logic               timebase_wake_enable,
    input  wire logic               watchdog_stop_option,
    input  wire logic               watchdog_enabled,
    // Interrupt sources
    input  wire logic [NUM_IRQ-1:0] irq_pending,
    input  wire logic [NUM_IRQ-1:0] irq_halt_wake,
    // Condition code mask
    input  wire logic               mask_set_sw,
    input  wire logic               mask_clear_sw,
    output logic                    condition_code_reg,
    // CPU control
    output logic                    cpu_clk_en,
    output logic                    periph_clk_en,
    output logic                    timebase_clk_en,
    output logic                    osc_enable,
    output logic                    vector_load,
    output logic [15:0]             vector_addr,
    output logic                    cc_push,
    output logic                    cc_pop,
    output logic                    watchdog_reset_req,
    output lpm_pkg::lpm_mode_type   mode
);
    import lpm_pkg::*;

    lpm_mode_type next_mode;
    logic         wake;
    logic [3:0]   irq_index;
    logic [3:0]   pending_index;
    logic         from_halt;
    logic         stacked_mask;
    logic         timer_start;
    logic         timer_busy;
    logic         timer_done;
    logic         in_halt;
    logic [NUM_IRQ-1:0] wake_sources;
    logic         reset_kick;

    assign in_halt = (mode == LPM_HALT);

    // Active Halt only hears the time base and halt-capable lines
    assign wake_sources = (mode == LPM_AHALT)
        ? (irq_pending & (irq_halt_wake | (NUM_IRQ'(1) << LPM_IRQ_TIMEBASE)))
        : irq_pending;

    lpm_irq_select #(
        .NUM_IRQ       (NUM_IRQ)
    ) u_select (
        .irq_pending   (wake_sources),
        .irq_halt_wake (irq_halt_wake),
        .in_halt       (in_halt),
        .wake          (wake),
        .irq_index     (irq_index)
    );

    lpm_wake_timer #(
        .DELAY   (WAKE_DELAY)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (timer_start),
        .busy    (timer_busy),
        .done    (timer_done)
    );

    // Vector for a given interrupt index, two bytes per slot below TRAP
    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        vector_of = LPM_VECTOR_TOP - 16'h0002 - {11'h000, idx, 1'b0};
    endfunction

    // Mode sequencing
    always_comb begin
        next_mode   = mode;
        timer_start = 1'b0;
        case (mode)
            LPM_RUN: begin
                if (wait_for_event_instruction) begin
                    next_mode = LPM_WAIT;
                end else if (halt_instruction) begin
                    if (timebase_wake_enable) begin
                        next_mode = LPM_AHALT;
                    end else begin
                        next_mode = LPM_HALT;
                    end
                end
            end
            LPM_WAIT: begin
                if (wake) begin
                    next_mode = LPM_SERVICE;
                end
            end
            LPM_AHALT, LPM_HALT: begin
                // Pending at entry wakes next cycle, mask already clear
                if (wake) begin
                    next_mode   = LPM_WAKEUP;
                    timer_start = 1'b1;
                end
            end
            LPM_WAKEUP: begin
                if (timer_done) begin
                    next_mode = LPM_SERVICE;
                end
            end
            LPM_SERVICE: begin
                next_mode = LPM_RUN;
            end
            default: begin
                next_mode = LPM_RUN;
            end
        endcase
        // Reset leaves us in the wake state; the delay must start too
        if (reset_kick) begin
            timer_start = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode <= LPM_WAKEUP;
        end else begin
            mode <= next_mode;
        end
    end

    // Reset also passes through the stabilisation delay
    logic reset_seen;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reset_seen <= 1'b1;
        end else if (mode == LPM_SERVICE) begin
            reset_seen <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reset_kick <= 1'b1;
        end else begin
            reset_kick <= 1'b0;
        end
    end

    // Latch the waking source for service after the delay
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending_index <= '0;
            from_halt     <= 1'b0;
        end else if ((mode == LPM_AHALT || mode == LPM_HALT || mode == LPM_WAIT) && wake) begin
            pending_index <= irq_index;
            from_halt     <= in_halt;
        end
    end

    // Interrupt mask; set wins since entering service masks
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            condition_code_reg <= LPM_IMASK_RESET;
            stacked_mask       <= 1'b0;
        end else if (mode == LPM_SERVICE && !reset_seen) begin
            stacked_mask       <= condition_code_reg;
            condition_code_reg <= 1'b1;
        end else if (mode == LPM_RUN && next_mode == LPM_WAIT) begin
            condition_code_reg <= 1'b0;
        end else if (mode == LPM_RUN && next_mode == LPM_AHALT) begin
            condition_code_reg <= 1'b0;
        end else if (mode == LPM_RUN && next_mode == LPM_HALT) begin
            condition_code_reg <= 1'b0;
        end else if (irq_return) begin
            condition_code_reg <= stacked_mask;
        end else if (mask_set_sw) begin
            condition_code_reg <= 1'b1;
        end else if (mask_clear_sw) begin
            condition_code_reg <= 1'b0;
        end
    end

    // Vector load and stack strobes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vector_load <= 1'b0;
            vector_addr <= LPM_RESET_VECTOR;
            cc_push     <= 1'b0;
            cc_pop      <= 1'b0;
        end else begin
            vector_load <= 1'b0;
            cc_push     <= 1'b0;
            cc_pop      <= irq_return;
            if (mode == LPM_SERVICE) begin
                vector_load <= 1'b1;
                if (reset_seen) begin
                    vector_addr <= LPM_RESET_VECTOR;
                end else begin
                    vector_addr <= vector_of(pending_index);
                    cc_push     <= 1'b1;
                end
            end
        end
    end

    // Clock gating; oscillator restarts as soon as the wake begins
    always_comb begin
        cpu_clk_en      = (mode == LPM_RUN) || (mode == LPM_SERVICE);
        periph_clk_en   = (mode == LPM_RUN) || (mode == LPM_WAIT)
                        || (mode == LPM_SERVICE);
        timebase_clk_en = (mode != LPM_HALT);
        osc_enable      = (mode != LPM_HALT);
        if (mode == LPM_AHALT) begin
            periph_clk_en = 1'b0;
        end
    end

    // Watchdog: Active Halt never resets; Halt resets when option forbids
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            watchdog_reset_req <= 1'b0;
        end else begin
            watchdog_reset_req <= 1'b0;
            if (mode == LPM_RUN && halt_instruction && !wait_for_event_instruction
                && watchdog_enabled && !timebase_wake_enable
                && !watchdog_stop_option) begin
                watchdog_reset_req <= 1'b1;
            end
        end
    end

    // Reset start of delay timer shares the timer with interrupt wakes
    logic unused_ok;
    assign unused_ok = timer_busy & from_halt;
endmodule // lpm_controller
`default_nettype wire

// >>> lpm_cpu_model.sv
// Partner model: CPU core strobes and interrupt source levels.
// Assumes it is driven from the bench a short delay after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
    // Clock and answers
    input  wire logic    sys_clk,
    input  wire logic    vector_load,
    // Strobes and sources
    output logic         wait_for_event_instruction,
    output logic         halt_instruction,
    output logic         irq_return,
    output logic [13:0]  irq_pending
);
    initial begin
        wait_for_event_instruction = 1'b0;
        halt_instruction = 1'b0;
        irq_return = 1'b0;
        irq_pending = 14'h0000;
    end
    task automatic strobe(input logic halt);
        @(posedge sys_clk) #1;
        halt_instruction = halt;
        wait_for_event_instruction = !halt;
        @(posedge sys_clk) #1;
        halt_instruction = 1'b0;
        wait_for_event_instruction = 1'b0;
    endtask
    task automatic set_pend(input logic [13:0] v);
        irq_pending = v;
    endtask
    // Request latch drops at vector fetch; routine is kept short
    always @(posedge sys_clk) begin
        #2;
        if (vector_load === 1'b1) begin
            irq_pending = 14'h0000;
            repeat (3) @(posedge sys_clk);
            #1 irq_return = 1'b1;
            @(posedge sys_clk) #1 irq_return = 1'b0;
        end
    end
endmodule // lpm_cpu_model
`default_nettype wire

// >>> lpm_controller_assertions.sv
// Checker for lpm_controller: mode, mask and clock relations at the ports.
// Assumes a single clock domain; bound to every lpm_controller.
`timescale 1ns/1ps
`default_nettype none
module lpm_controller_checker #(
    parameter int unsigned WAKE_DELAY = 4096,
    parameter int unsigned NUM_IRQ    = 14
) (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  wait_for_event_instruction,
    input wire logic                  halt_instruction,
    input wire logic                  timebase_wake_enable,
    input wire logic [NUM_IRQ-1:0]    irq_pending,
    input wire logic [NUM_IRQ-1:0]    irq_halt_wake,
    input wire logic                  condition_code_reg,
    input wire logic                  cpu_clk_en,
    input wire logic                  periph_clk_en,
    input wire logic                  timebase_clk_en,
    input wire logic                  osc_enable,
    input wire logic                  vector_load,
    input wire logic                  watchdog_reset_req,
    input wire lpm_pkg::lpm_mode_type mode
);
    import lpm_pkg::*;
    logic [15:0] wake_count;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || mode != LPM_WAKEUP) wake_count <= 16'h0000;
        else wake_count <= wake_count + 16'h0001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_wait_entry: assert property (
        wait_for_event_instruction && mode == LPM_RUN && irq_pending == '0
        |-> ##[1:3] mode == LPM_WAIT) else $error("wait mode not entered");
    a_mask_cleared: assert property (
        mode inside {LPM_WAIT, LPM_AHALT, LPM_HALT} |-> ##[0:1] !condition_code_reg)
        else $error("mask not cleared in low power mode");
    a_halt_select: assert property (
        halt_instruction && mode == LPM_RUN && irq_pending == '0
        |-> ##[1:3] mode == (timebase_wake_enable ? LPM_AHALT : LPM_HALT))
        else $error("wrong halt variant");
    a_ahalt_clocks: assert property (
        mode == LPM_AHALT [*2] |-> osc_enable && timebase_clk_en && !periph_clk_en
        && !cpu_clk_en) else $error("active halt clocks wrong");
    a_halt_osc_off: assert property (
        mode == LPM_HALT [*2] |-> !osc_enable && !periph_clk_en && !cpu_clk_en)
        else $error("halt clocks wrong");
    a_ahalt_no_wdg: assert property (
        mode == LPM_AHALT && timebase_wake_enable |-> !watchdog_reset_req)
        else $error("watchdog reset in active halt");
    a_halt_holds: assert property (
        mode == LPM_HALT && (irq_pending & irq_halt_wake) == '0 |=> mode == LPM_HALT)
        else $error("halt left without a wake source");
    a_wait_wake: assert property (
        mode == LPM_WAIT && irq_pending != '0 |-> ##[1:3] mode != LPM_WAIT)
        else $error("wait not left on interrupt");
    a_wake_delay: assert property (
        $past(mode) == LPM_WAKEUP && mode != LPM_WAKEUP
        |-> wake_count >= WAKE_DELAY - 1 && wake_count <= WAKE_DELAY + 2)
        else $error("wake delay length wrong");
    a_run_clocks: assert property (
        mode == LPM_RUN [*2] |-> cpu_clk_en && periph_clk_en && osc_enable)
        else $error("run clocks not restored");
    a_service_mask: assert property (
        vector_load |-> ##[0:2] condition_code_reg) else $error("mask not set in service");
    c_wait: cover property (mode == LPM_WAIT ##1 mode != LPM_WAIT);
    c_ahalt: cover property (mode == LPM_AHALT ##1 mode == LPM_WAKEUP);
    c_halt: cover property (mode == LPM_HALT ##1 mode == LPM_WAKEUP);
endmodule // lpm_controller_checker
bind lpm_controller lpm_controller_checker #(.WAKE_DELAY(WAKE_DELAY), .NUM_IRQ(NUM_IRQ)) chk_u (
    .sys_clk, .rst_n, .wait_for_event_instruction, .halt_instruction,
    .timebase_wake_enable, .irq_pending, .irq_halt_wake, .condition_code_reg,
    .cpu_clk_en, .periph_clk_en, .timebase_clk_en, .osc_enable, .vector_load,
    .watchdog_reset_req, .mode);
`default_nettype wire

// >>> low_power_mode_controller_test.sv
// Testbench for lpm_controller with a CPU core partner model.
// Assumes a 20 MHz clock and a wake-up delay shortened to 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_test;
    import lpm_pkg::*;
    localparam int unsigned DLY = 16;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         timebase_wake_enable = 1'b0;
    logic         watchdog_enabled = 1'b0;
    logic         watchdog_stop_option = 1'b0;
    logic         mask_set_sw = 1'b0;
    logic         mask_clear_sw = 1'b0;
    logic [13:0]  irq_halt_wake = 14'h003C;
    logic         wait_for_event_instruction, halt_instruction, irq_return;
    logic         condition_code_reg, cpu_clk_en, periph_clk_en, timebase_clk_en;
    logic         osc_enable, vector_load, watchdog_reset_req;
    logic [13:0]  irq_pending;
    logic [15:0]  vector_addr;
    lpm_mode_type mode;
    int           bad_count = 0;
    int           checks_done = 0;
    always #25 sys_clk = ~sys_clk;
    lpm_cpu_model cpu_u (.sys_clk, .vector_load, .wait_for_event_instruction,
        .halt_instruction, .irq_return, .irq_pending);
    lpm_controller #(.WAKE_DELAY(DLY)) dut_u (
        .sys_clk, .rst_n, .wait_for_event_instruction, .halt_instruction, .irq_return,
        .timebase_wake_enable, .watchdog_stop_option, .watchdog_enabled,
        .irq_pending, .irq_halt_wake, .mask_set_sw, .mask_clear_sw,
        .condition_code_reg, .cpu_clk_en, .periph_clk_en, .timebase_clk_en, .osc_enable,
        .vector_load, .vector_addr, .cc_push(), .cc_pop(), .watchdog_reset_req, .mode);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait so a missing vector fetch cannot hang the run
    task automatic await_vec(output int n);
        n = 0;
        while (vector_load !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic t_wait;
        int n;
        cpu_u.strobe(1'b0);
        cyc(3);
        check(16'(mode), 16'(LPM_WAIT));
        check(16'({cpu_clk_en, periph_clk_en, condition_code_reg}), 16'h0002);
        cpu_u.set_pend(14'h0080);
        await_vec(n);
        check(vector_addr, 16'hFFEC);
        cyc(2);
        check(16'(condition_code_reg), 16'h0001);
        cyc(10);
        check(16'({mode, condition_code_reg}), 16'h0000);
        $display("test wait done");
    endtask
    task automatic t_halt(input logic tbe, input logic [13:0] src, input logic [15:0] vec);
        int n;
        timebase_wake_enable = tbe;
        watchdog_enabled = tbe;
        cpu_u.strobe(1'b1);
        cyc(3);
        check(16'(mode), tbe ? 16'(LPM_AHALT) : 16'(LPM_HALT));
        check(16'({osc_enable, timebase_clk_en, periph_clk_en, cpu_clk_en}),
              tbe ? 16'h000C : 16'h0000);
        check(16'(watchdog_reset_req), 16'h0000);
        if (!tbe) begin
            cpu_u.set_pend(14'h0002);
            cyc(5);
            check(16'(mode), 16'(LPM_HALT));
            cpu_u.set_pend(14'h0000);
        end
        cpu_u.set_pend(src);
        cyc(3);
        check(16'({mode, osc_enable}), 16'({LPM_WAKEUP, 1'b1}));
        await_vec(n);
        check(16'(n + 3 >= DLY && n + 3 <= DLY + 6), 16'h0001);
        check(vector_addr, vec);
        cyc(10);
        check(16'({mode, cpu_clk_en, periph_clk_en}), 16'h0003);
        $display("test halt done");
    endtask
    task automatic t_pending;
        int n;
        timebase_wake_enable = 1'b0;
        cpu_u.set_pend(14'h0004);
        cpu_u.strobe(1'b1);
        cyc(3);
        check(16'(mode == LPM_HALT), 16'h0000);
        await_vec(n);
        check(vector_addr, 16'hFFF6);
        cyc(10);
        check(16'(mode), 16'(LPM_RUN));
        $display("test pending done");
    endtask
    task automatic t_watchdog;
        int n;
        timebase_wake_enable = 1'b0;
        watchdog_enabled = 1'b1;
        watchdog_stop_option = 1'b0;
        cpu_u.strobe(1'b1);
        check(16'(watchdog_reset_req), 16'h0001);
        // Mid-run reset also wakes from Halt through the delay
        rst_n = 1'b0;
        cyc(4);
        rst_n = 1'b1;
        await_vec(n);
        check(vector_addr, LPM_RESET_VECTOR);
        cyc(10);
        check(16'(mode), 16'(LPM_RUN));
        watchdog_stop_option = 1'b1;
        cpu_u.strobe(1'b1);
        check(16'(watchdog_reset_req), 16'h0000);
        cpu_u.set_pend(14'h0004);
        await_vec(n);
        check(vector_addr, 16'hFFF6);
        cyc(10);
        watchdog_enabled = 1'b0;
        mask_set_sw = 1'b1;
        cyc(1);
        mask_set_sw = 1'b0;
        check(16'(condition_code_reg), 16'h0001);
        mask_clear_sw = 1'b1;
        cyc(1);
        mask_clear_sw = 1'b0;
        check(16'(condition_code_reg), 16'h0000);
        $display("test watchdog done");
    endtask
    initial begin
        int n;
        repeat (4) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        await_vec(n);
        check(vector_addr, LPM_RESET_VECTOR);
        cyc(10);
        check(16'(mode), 16'(LPM_RUN));
        t_wait;
        t_halt(1'b1, 14'h0002, 16'hFFF8);
        t_halt(1'b0, 14'h0004, 16'hFFF6);
        t_pending;
        t_watchdog;
        summarize;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        summarize;
    end
endmodule // low_power_mode_controller_test
`default_nettype wire
